// [hw/asmm_pkg.sv]
package asmm_pkg;

	// ***************************************************************
	// Datapath widths and bit positions
	// ***************************************************************
	localparam int unsigned ASMM_W      = 32;
	localparam int unsigned ASMM_PW     = 64;
	localparam int unsigned ASMM_SHW    = 5;
	localparam int unsigned ASMM_MSB    = 31;
	localparam int unsigned ASMM_P_SIGN = 63;
	localparam int unsigned ASMM_P_HI   = 62;
	localparam int unsigned ASMM_P_LO   = 31;

	// ***************************************************************
	// Bus map: one control/status word, one flag word
	// ***************************************************************
	localparam logic [11:0] ASMM_FLAGS_OFS = 12'h000;
	localparam logic [11:0] ASMM_CTRL_OFS  = 12'h004;
	localparam logic [3:0]  ASMM_FLAGS_RST = 4'h0;
	localparam int unsigned ASMM_FZ = 3;
	localparam int unsigned ASMM_FN = 2;
	localparam int unsigned ASMM_FC = 1;
	localparam int unsigned ASMM_FV = 0;
	localparam int unsigned ASMM_FW        = 4;
	localparam int unsigned ASMM_HALT_BIT  = 0;
	localparam int unsigned ASMM_ISSUE_BIT = 1;

	// ***************************************************************
	// Operation select (one-hot)
	// ***************************************************************
	typedef enum logic [4:0]
	{
		ASMM_OP_SHR = 5'h01,
		ASMM_OP_MAX = 5'h02,
		ASMM_OP_MIN = 5'h04,
		ASMM_OP_MOV = 5'h08,
		ASMM_OP_MUL = 5'h10
	} asmm_op_e;

endpackage

// [hw/asmm_shifter.sv]
`timescale 1ns/100ps
module asmm_shifter
	import asmm_pkg::*;
(
	input  wire logic [asmm_pkg::ASMM_W-1:0]   src_val,
	input  wire logic [asmm_pkg::ASMM_SHW-1:0] shift_amt,
	output logic      [asmm_pkg::ASMM_W-1:0]   shifted,
	output logic                               last_out
);
	// ***************************************************************
	// Logical right shift with last bit shifted out
	// ***************************************************************
	logic [ASMM_W:0] ext_w;

	// Extra low bit catches the bit that falls off last
	assign ext_w    = {src_val, 1'b0} >> shift_amt;            // RULE_01
	assign shifted  = ext_w[ASMM_W:1];                           // RULE_01
	assign last_out = (shift_amt != '0) ? ext_w[0] : 1'b0;       // RULE_02
endmodule

// [hw/asmm_multiplier.sv]
`timescale 1ns/100ps
module asmm_multiplier
	import asmm_pkg::*;
(
	input  wire logic [asmm_pkg::ASMM_W-1:0] op_a,
	input  wire logic [asmm_pkg::ASMM_W-1:0] op_b,
	output logic      [asmm_pkg::ASMM_W-1:0] prod_lo,
	output logic                             prod_neg,
	output logic                             prod_ovf
);
	// ***************************************************************
	// Signed 32x32 product, low word kept
	// ***************************************************************
	logic signed [ASMM_PW-1:0] prod_w;

	// Single-cycle combinational multiply; timing left to synthesis
	assign prod_w   = $signed(op_a) * $signed(op_b);               // RULE_12
	assign prod_lo  = prod_w[ASMM_W-1:0];                           // RULE_12
	assign prod_neg = prod_w[ASMM_P_SIGN];                          // RULE_13
	// Overflow when any of bits 62:31 disagrees with the sign
	assign prod_ovf = (prod_w[ASMM_P_HI:ASMM_P_LO]
		!= {(ASMM_P_HI-ASMM_P_LO+1){prod_w[ASMM_P_SIGN]}});        // RULE_14
endmodule

// [hw/asmm_alu.sv]
// Behaviour
// [RULE_01] Right shift of first source by low five bits of second, zero fill
// [RULE_02] With flags, carry is last bit shifted out; zero amount clears it
// [RULE_03] Shift and copy set zero and negative from result; overflow kept
// [RULE_04] Flags change only when the flag-set request is present; a bus write to the flag word while halted also sets them
// [RULE_05] Result write and flags happen only when condition is true
// [RULE_06] Maximum picks second source when signed second >= first
// [RULE_07] Maximum flags: zero, negative, overflow from first minus second
// [RULE_08] Maximum carry set when second source was selected
// [RULE_09] Minimum picks second source when signed second <= first
// [RULE_10] Minimum flags as maximum; carry set when second selected
// [RULE_11] Copy passes source unchanged; carry and overflow untouched
// [RULE_12] Signed multiply writes low 32 bits of 64-bit product
// [RULE_13] Multiply zero from written word, negative from product sign; carry kept
// [RULE_14] Multiply overflow when product bits 62:31 differ from sign
// [RULE_15] Subtract overflow: signs differ and result sign differs from first
`timescale 1ns/100ps
module asmm_alu
	import asmm_pkg::*;
(
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	input  wire logic                          clk_en,
	input  wire logic                          issue_valid,
	input  wire asmm_pkg::asmm_op_e            op_sel,
	input  wire logic [asmm_pkg::ASMM_W-1:0]   src1,
	input  wire logic [asmm_pkg::ASMM_W-1:0]   src2,
	input  wire logic                          condition_select,
	input  wire logic                          flag_set_req,
	output logic      [asmm_pkg::ASMM_W-1:0]   result_q,
	output logic                               result_we_q,
	output logic                               flags_we_q,
	output logic                               flag_z_q,
	output logic                               flag_n_q,
	output logic                               flag_c_q,
	output logic                               flag_v_q,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr
);
	import asmm_pkg::*;

	// ***************************************************************
	// Sub-units
	// ***************************************************************
	logic [ASMM_W-1:0] shr_w;
	logic              shr_c_w;
	logic [ASMM_W-1:0] mul_w;
	logic              mul_n_w;
	logic              mul_v_w;

	asmm_shifter u_shift
	(
		.src_val   (src1),
		.shift_amt (src2[ASMM_SHW-1:0]),
		.shifted   (shr_w),
		.last_out  (shr_c_w)
	);

	asmm_multiplier u_mul
	(
		.op_a     (src1),
		.op_b     (src2),
		.prod_lo  (mul_w),
		.prod_neg (mul_n_w),
		.prod_ovf (mul_v_w)
	);

	// ***************************************************************
	// Compare path for maximum and minimum
	// ***************************************************************
	logic [ASMM_W-1:0] diff_w;
	logic              sub_v_w;
	logic              ge_w;
	logic              le_w;
	logic              eq_w;

	assign diff_w  = src1 - src2;                                 // RULE_07
	// Signs differ and result sign left first source's sign
	assign sub_v_w = (src1[ASMM_MSB] ^ src2[ASMM_MSB])
		& (diff_w[ASMM_MSB] ^ src1[ASMM_MSB]);                    // RULE_15
	assign eq_w    = (src1 == src2);                              // RULE_07
	assign ge_w    = ($signed(src2) >= $signed(src1));            // RULE_06
	assign le_w    = ($signed(src2) <= $signed(src1));            // RULE_09

	// ***************************************************************
	// Flag register state and bus-visible controls
	// ***************************************************************
	logic [3:0] flags_q;
	logic [3:0] flags_d;
	logic       halt_q;
	logic       halt_d;
	logic [31:0] prdata_d;

	// ***************************************************************
	// Result and next-flag selection
	// ***************************************************************
	logic [ASMM_W-1:0] res_w;
	logic [3:0]        newf_w;
	logic              shr_z_w;
	logic              mov_z_w;
	logic              mul_z_w;

	// Zero tests sit on each unit's own output, not on the selected
	// result, so the selector below never feeds back into itself
	assign shr_z_w = (shr_w == '0);                               // RULE_03
	assign mov_z_w = (src1 == '0);                                // RULE_03
	assign mul_z_w = (mul_w == '0);                               // RULE_13

	// Carry and overflow default to held values per operation
	always_comb
	begin
		res_w  = src1;
		newf_w = flags_q;
		unique case (op_sel)
			ASMM_OP_SHR:
			begin
				res_w = shr_w;                                    // RULE_01
				newf_w[ASMM_FZ] = shr_z_w;                        // RULE_03
				newf_w[ASMM_FN] = res_w[ASMM_MSB];                // RULE_03
				newf_w[ASMM_FC] = shr_c_w;                        // RULE_02
			end
			ASMM_OP_MAX:
			begin
				res_w = ge_w ? src2 : src1;                       // RULE_06
				newf_w[ASMM_FZ] = eq_w;                           // RULE_07
				newf_w[ASMM_FN] = diff_w[ASMM_MSB];               // RULE_07
				newf_w[ASMM_FV] = sub_v_w;                        // RULE_07
				newf_w[ASMM_FC] = ge_w;                           // RULE_08
			end
			ASMM_OP_MIN:
			begin
				res_w = le_w ? src2 : src1;                       // RULE_09
				newf_w[ASMM_FZ] = eq_w;                           // RULE_10
				newf_w[ASMM_FN] = diff_w[ASMM_MSB];               // RULE_10
				newf_w[ASMM_FV] = sub_v_w;                        // RULE_10
				newf_w[ASMM_FC] = le_w;                           // RULE_10
			end
			ASMM_OP_MOV:
			begin
				res_w = src1;                                     // RULE_11
				newf_w[ASMM_FZ] = mov_z_w;                        // RULE_03
				newf_w[ASMM_FN] = res_w[ASMM_MSB];                // RULE_03
			end
			ASMM_OP_MUL:
			begin
				res_w = mul_w;                                    // RULE_12
				newf_w[ASMM_FZ] = mul_z_w;                        // RULE_13
				newf_w[ASMM_FN] = mul_n_w;                        // RULE_13
				newf_w[ASMM_FV] = mul_v_w;                        // RULE_14
			end
			default:
			begin
				res_w  = src1;
				newf_w = flags_q;
			end
		endcase
	end

	// ***************************************************************
	// Commit qualification
	// ***************************************************************
	logic exec_w;
	logic fupd_w;
	logic bus_wr_w;
	logic bus_rd_w;
	logic sel_flags_w;
	logic sel_ctrl_w;

	// Software halt blocks issue so bus writes never race the pipeline
	assign exec_w   = issue_valid & condition_select & ~halt_q;   // RULE_05
	assign fupd_w   = exec_w & flag_set_req;                      // RULE_04
	assign sel_flags_w = (paddr == ASMM_FLAGS_OFS);
	assign sel_ctrl_w  = (paddr == ASMM_CTRL_OFS);
	assign bus_wr_w = psel & penable & pwrite;
	assign bus_rd_w = psel & ~penable & ~pwrite;

	// ***************************************************************
	// Bus word fields
	// ***************************************************************
	logic [ASMM_FW-1:0] wr_flags_w;
	logic               wr_halt_w;
	logic               unmapped_w;
	logic [31:0]        rd_flags_word_w;
	logic [31:0]        rd_ctrl_word_w;

	// Upper bits read as zero and are dropped on write
	assign wr_flags_w      = pwdata[ASMM_FW-1:0];
	assign wr_halt_w       = pwdata[ASMM_HALT_BIT];
	assign unmapped_w      = ~(sel_flags_w | sel_ctrl_w);
	assign rd_flags_word_w = {{(ASMM_W-ASMM_FW){1'b0}}, flags_q};

	// Control word: halt bit and a live view of the issue strobe
	always_comb
	begin
		rd_ctrl_word_w                 = '0;
		rd_ctrl_word_w[ASMM_HALT_BIT]  = halt_q;
		rd_ctrl_word_w[ASMM_ISSUE_BIT] = issue_valid;
	end

	// Bus write to the flag word only takes hold while halted;
	// a datapath update in the same cycle wins over the bus
	always_comb
	begin
		flags_d = flags_q;
		halt_d  = halt_q;
		if (fupd_w)
			flags_d = newf_w;                                     // RULE_04
		else if (bus_wr_w & sel_flags_w & halt_q)
			flags_d = wr_flags_w;
		if (bus_wr_w & sel_ctrl_w)
			halt_d = wr_halt_w;
	end

	// Read data registered in setup so the access phase sees it
	always_comb
	begin
		prdata_d = prdata;
		if (bus_rd_w)
		begin
			if (sel_flags_w)
				prdata_d = rd_flags_word_w;
			else if (sel_ctrl_w)
				prdata_d = rd_ctrl_word_w;
			else
				prdata_d = '0;
		end
	end

	// ***************************************************************
	// Registers
	// ***************************************************************
	logic [ASMM_W-1:0] result_d;

	// Result holds between executed operations
	assign result_d = exec_w ? res_w : result_q;                  // RULE_05

	// Flag word; clock enable low freezes it like every other flop
	always_ff @(posedge core_clk)
	begin
		if (rst)
			flags_q <= ASMM_FLAGS_RST;
		else if (clk_en)
			flags_q <= flags_d;                                   // RULE_04
	end

	// Software halt; reset releases the issue path
	always_ff @(posedge core_clk)
	begin
		if (rst)
			halt_q <= 1'b0;
		else if (clk_en)
			halt_q <= halt_d;
	end

	// Write-back result and one-cycle pulses; a frozen clock enable
	// stretches a pulse, which the pipeline must allow for
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			result_q    <= '0;
			result_we_q <= 1'b0;
			flags_we_q  <= 1'b0;
		end
		else if (clk_en)
		begin
			result_q    <= result_d;                              // RULE_05
			result_we_q <= exec_w;                                // RULE_05
			flags_we_q  <= fupd_w;                                // RULE_04
		end
	end

	// Bus read data, captured in the setup cycle
	always_ff @(posedge core_clk)
	begin
		if (rst)
			prdata <= '0;
		else if (clk_en)
			prdata <= prdata_d;
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	assign flag_z_q = flags_q[ASMM_FZ];
	assign flag_n_q = flags_q[ASMM_FN];
	assign flag_c_q = flags_q[ASMM_FC];
	assign flag_v_q = flags_q[ASMM_FV];
	// Zero-wait slave; unmapped addresses answer with an error.
	// No wait state is needed while clk_en is high, since read data is captured in the setup cycle
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & unmapped_w;
endmodule

// [verification/asmm_alu_sva.sv]
`timescale 1ns/100ps
module asmm_alu_sva
	import asmm_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               rst,
	input wire logic               clk_en,
	input wire logic               issue_valid,
	input wire asmm_pkg::asmm_op_e op_sel,
	input wire logic [31:0]        src1,
	input wire logic [31:0]        src2,
	input wire logic               condition_select,
	input wire logic               flag_set_req,
	input wire logic [31:0]        result_q,
	input wire logic               result_we_q,
	input wire logic               flags_we_q,
	input wire logic               flag_c_q,
	input wire logic               flag_v_q
);
	// ***************************************************************
	// Reference terms
	// ***************************************************************
	// Halt is not visible here, so operation checks key on the result or flag write pulse
	wire logic ex = clk_en && issue_valid && condition_select;
	wire logic ge = $signed(src2) >= $signed(src1);
	wire logic le = $signed(src2) <= $signed(src1);
	wire logic sc = (src2[4:0] != 5'h00) && src1[src2[4:0] - 5'h01];

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// ***************************************************************
	// Assertions
	// ***************************************************************
	AST_SHR_RES: assert property (
		ex && op_sel == ASMM_OP_SHR ##1 result_we_q
		|-> result_q == $past(src1 >> src2[4:0])) else $error("shift result");
	AST_SHR_CARRY: assert property (
		ex && op_sel == ASMM_OP_SHR ##1 flags_we_q
		|-> flag_c_q == $past(sc)) else $error("shift carry");
	AST_MAX_RES: assert property (
		ex && op_sel == ASMM_OP_MAX ##1 result_we_q
		|-> result_q == $past(ge ? src2 : src1)) else $error("max result");
	AST_MIN_RES: assert property (
		ex && op_sel == ASMM_OP_MIN ##1 result_we_q
		|-> result_q == $past(le ? src2 : src1)) else $error("min result");
	AST_MUL_RES: assert property (
		ex && op_sel == ASMM_OP_MUL ##1 result_we_q
		|-> result_q == $past(src1 * src2)) else $error("multiply low");
	AST_MOV_CV: assert property (
		ex && op_sel == ASMM_OP_MOV ##1 result_we_q
		|-> $stable(flag_c_q) && $stable(flag_v_q)) else $error("copy c/v");
	AST_NO_FLAG: assert property (
		ex && !flag_set_req |=> !flags_we_q) else $error("flags written");
	AST_COND: assert property (
		clk_en && !(issue_valid && condition_select) |=> !result_we_q)
		else $error("write without condition");

	cover property (ex && op_sel == ASMM_OP_MUL && flag_set_req);
	cover property (flags_we_q && flag_v_q);
	cover property (clk_en && issue_valid && !condition_select);
endmodule

bind asmm_alu asmm_alu_sva asmm_alu_sva_inst (.core_clk(core_clk), .rst(rst),
	.clk_en(clk_en), .issue_valid(issue_valid), .op_sel(op_sel),
	.src1(src1), .src2(src2), .condition_select(condition_select),
	.flag_set_req(flag_set_req), .result_q(result_q),
	.result_we_q(result_we_q), .flags_we_q(flags_we_q),
	.flag_c_q(flag_c_q), .flag_v_q(flag_v_q));

// [verification/asmm_pipe_model.sv]
`timescale 1ns/100ps
module asmm_pipe_model
	import asmm_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        result_we_q,
	input  wire logic [31:0] result_q,
	output logic      [15:0] wb_cnt_q,
	output logic      [31:0] wb_reg_q
);
	// Register-file port; assumes clk_en high, else a held pulse recounts
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			wb_cnt_q <= 16'h0000;
			wb_reg_q <= 32'h00000000;
		end
		else if (result_we_q)
		begin
			wb_cnt_q <= wb_cnt_q + 16'h0001;
			wb_reg_q <= result_q;
		end
	end
endmodule

// [verification/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
	import asmm_pkg::*;
	typedef struct {asmm_op_e o; logic [31:0] a, b, r, g; logic f;} asmm_row_s;
	logic core_clk, rst, clk_en, issue_valid, condition_select, flag_set_req;
	logic result_we_q, flags_we_q, flag_z_q, flag_n_q, flag_c_q, flag_v_q;
	logic psel, penable, pwrite, pready, pslverr, er;
	logic [31:0] src1, src2, result_q, pwdata, prdata, rd, fw;
	logic [11:0] paddr;
	logic [15:0] wb_cnt_q;
	logic [31:0] wb_reg_q;
	asmm_op_e op_sel;
	int errors, samples_checked;
	assign fw = {28'h0, flag_z_q, flag_n_q, flag_c_q, flag_v_q};

	// ***************************************************************
	// Table: op, src1, src2, result, flags {z,n,c,v}, flag request
	// ***************************************************************
	asmm_row_s rows [14] = '{
		'{ASMM_OP_SHR, 32'h80000001, 32'h21, 32'h40000000, 32'h2, 1'h1},
		'{ASMM_OP_SHR, 32'hffffffff, 32'h0, 32'hffffffff, 32'h4, 1'h1},
		'{ASMM_OP_SHR, 32'h80000000, 32'h1f, 32'h1, 32'h0, 1'h1},
		'{ASMM_OP_MAX, 32'hffffffff, 32'h1, 32'h1, 32'h6, 1'h1},
		'{ASMM_OP_MAX, 32'h80000000, 32'h1, 32'h1, 32'h3, 1'h1},
		'{ASMM_OP_MAX, 32'h5, 32'h5, 32'h5, 32'ha, 1'h1},
		'{ASMM_OP_MIN, 32'h7fffffff, 32'hffffffff, 32'hffffffff, 32'h7, 1'h1},
		'{ASMM_OP_MOV, 32'h0, 32'hffffffff, 32'h0, 32'hb, 1'h1},
		'{ASMM_OP_MUL, 32'h80000000, 32'h2, 32'h0, 32'hf, 1'h1},
		'{ASMM_OP_MIN, 32'h2, 32'h3, 32'h2, 32'h4, 1'h1},
		'{ASMM_OP_MUL, 32'h10000, 32'h10000, 32'h0, 32'h9, 1'h1},
		'{ASMM_OP_SHR, 32'h3, 32'h1, 32'h1, 32'h3, 1'h1},
		'{ASMM_OP_MUL, 32'hfffffffd, 32'h7, 32'hffffffeb, 32'h6, 1'h1},
		'{ASMM_OP_MOV, 32'h80000000, 32'h0, 32'h80000000, 32'h6, 1'h0}};

	asmm_alu asmm_alu_inst (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
		.issue_valid(issue_valid), .op_sel(op_sel), .src1(src1), .src2(src2),
		.condition_select(condition_select), .flag_set_req(flag_set_req),
		.result_q(result_q), .result_we_q(result_we_q), .flags_we_q(flags_we_q),
		.flag_z_q(flag_z_q), .flag_n_q(flag_n_q), .flag_c_q(flag_c_q),
		.flag_v_q(flag_v_q), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	asmm_pipe_model asmm_pipe_model_inst (.core_clk(core_clk), .rst(rst),
		.result_we_q(result_we_q), .result_q(result_q),
		.wb_cnt_q(wb_cnt_q), .wb_reg_q(wb_reg_q));

	// 40 MHz core clock
	initial
	begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ***************************************************************
	// Tasks
	// ***************************************************************
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask

	// One issue cycle, then look at the registered answer mid-cycle
	task run_op(input asmm_op_e o, input logic [31:0] a, b, input logic f, c);
		@(posedge core_clk);
		op_sel <= o;
		src1 <= a;
		src2 <= b;
		flag_set_req <= f;
		condition_select <= c;
		issue_valid <= 1'h1;
		@(posedge core_clk);
		issue_valid <= 1'h0;
		@(negedge core_clk);
	endtask

	// Setup then access; request held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (pready !== 1'h1 && k < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (k >= 16)
		begin
			errors++;
			conclude();
		end
	endtask

	task conclude();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ***************************************************************
	// Sequence
	// ***************************************************************
	initial
	begin
		{rst, clk_en, issue_valid, condition_select, flag_set_req} = 5'h18;
		{psel, penable, pwrite, paddr, pwdata, src1, src2} = '0;
		op_sel = ASMM_OP_MOV;
		repeat (12) @(posedge core_clk);
		rst <= 1'h0;
		foreach (rows[i])
		begin
			run_op(rows[i].o, rows[i].a, rows[i].b, rows[i].f, 1'h1);
			chk("result", rows[i].r, result_q);
			chk("flags", rows[i].g, fw);
		end // flag rows also
		// Last pulse reaches the register-file model one edge later
		@(negedge core_clk);
		chk("writebacks", 32'he, {16'h0, wb_cnt_q});
		chk("written back", rows[13].r, wb_reg_q);
		$display("table test done");
		// False condition must leave result and flags alone
		run_op(ASMM_OP_SHR, 32'h0, 32'h0, 1'h1, 1'h0);
		chk("result_we", 32'h0, {31'h0, result_we_q});
		chk("result", 32'h80000000, result_q);
		chk("flags", 32'h6, fw);
		$display("condition test done");
		// Halted issue refused; flag word writable only while halted
		apb(1'h1, ASMM_CTRL_OFS, 32'h1);
		run_op(ASMM_OP_MOV, 32'h0, 32'h0, 1'h1, 1'h1);
		chk("halted result_we", 32'h0, {31'h0, result_we_q});
		apb(1'h1, ASMM_FLAGS_OFS, 32'h9);
		apb(1'h0, ASMM_FLAGS_OFS, 32'h0);
		chk("flag word", 32'h9, rd);
		apb(1'h0, ASMM_CTRL_OFS, 32'h0);
		chk("ctrl word", 32'h1, rd);
		chk("pslverr", 32'h0, {31'h0, er});
		apb(1'h0, 12'h010, 32'h0);
		chk("pslverr", 32'h1, {31'h0, er});
		apb(1'h1, ASMM_CTRL_OFS, 32'h0);
		// Once running again, a bus write to the flag word is dropped
		apb(1'h1, ASMM_FLAGS_OFS, 32'h0);
		apb(1'h0, ASMM_FLAGS_OFS, 32'h0);
		chk("refused flag word", 32'h9, rd);
		chk("flags", 32'h9, fw);
		$display("bus test done");
		// Clock enable low freezes result and flags
		@(posedge core_clk);
		clk_en <= 1'h0;
		run_op(ASMM_OP_MOV, 32'h1234, 32'h0, 1'h1, 1'h1);
		chk("frozen result", 32'h80000000, result_q);
		chk("frozen flags", 32'h9, fw);
		@(posedge core_clk);
		clk_en <= 1'h1;
		run_op(ASMM_OP_MOV, 32'h1234, 32'h0, 1'h1, 1'h1);
		chk("result", 32'h1234, result_q);
		chk("flags", 32'h1, fw);
		$display("clock enable test done");
		// Mid-run reset returns result, flags and model to zero
		@(posedge core_clk);
		rst <= 1'h1;
		@(posedge core_clk);
		rst <= 1'h0;
		@(negedge core_clk);
		chk("reset result", 32'h0, result_q);
		chk("reset flags", 32'h0, fw);
		chk("reset writebacks", 32'h0, {16'h0, wb_cnt_q});
		$display("reset test done");
		conclude();
	end
endmodule
